//--- hw/bae_defines.svh
// bae_defines.svh: event codes, unit masks and field widths for the event select decoder
// assumes: included by bare name from hw/ sources
`ifndef BAE_DEFINES_SVH
`define BAE_DEFINES_SVH

`define BAE_CODE_W 8
`define BAE_MASK_W 8
`define BAE_INC_W 4

// event codes
`define BAE_EV_BR_RET 8'hc4
`define BAE_EV_BR_MISP 8'hc5
`define BAE_EV_NO_ALLOC 8'hca

// branch unit masks
`define BAE_UM_ANY 8'h00
`define BAE_UM_JCC 8'h7e
`define BAE_UM_FAR 8'hbf
`define BAE_UM_IND_JC 8'heb
`define BAE_UM_RET 8'hf7
`define BAE_UM_CALL 8'hf9
`define BAE_UM_IND_CALL 8'hfb
`define BAE_UM_REL_CALL 8'hfd
`define BAE_UM_TAKEN_JCC 8'hfe

// allocation unit masks
`define BAE_UM_ROB_FULL 8'h01
`define BAE_UM_RAT_STALL 8'h20
`define BAE_UM_ALL 8'h3f
`define BAE_UM_NOT_DELIV 8'h50

// reorder buffer free entry threshold
`define BAE_ROB_FREE_MIN 2

`endif

//--- hw/bae_pkg.sv
// bae_pkg: types for the event select decoder
// assumes: compiled before the decoder modules
package bae_pkg;
    // selected event class, one-hot
    typedef enum logic [3:0] {
        BAE_SEL_NONE = 4'b0001,
        BAE_SEL_BR = 4'b0010,
        BAE_SEL_MISP = 4'b0100,
        BAE_SEL_ALLOC = 4'b1000
    } bae_sel_t;
endpackage

//--- hw/bae_alloc_stall.sv
// bae_alloc_stall: per-cycle allocation stall conditions
// assumes: inputs are sampled on the core clock
`timescale 1ns/10ps
`default_nettype none
`include "bae_defines.svh"

module bae_alloc_stall #(
    parameter int ROB_W = 6
) (
    input wire logic i_no_alloc,
    input wire logic [ROB_W-1:0] i_rob_free,
    input wire logic i_alias_stall,
    input wire logic i_fe_empty,
    input wire logic i_be_stall,
    output logic o_rob_full,
    output logic o_rat_stall,
    output logic o_fe_any,
    output logic o_fe_not_deliv
);
    // elaboration check: threshold must fit
    if (ROB_W < 2) begin : g_bad_rob_w
        $error("ROB_W too small");
    end

    assign o_rob_full = i_no_alloc && (i_rob_free < ROB_W'(`BAE_ROB_FREE_MIN));
    assign o_rat_stall = i_no_alloc && i_alias_stall;
    assign o_fe_any = i_fe_empty;
    assign o_fe_not_deliv = i_fe_empty && !i_be_stall;
endmodule // bae_alloc_stall
`default_nettype wire

//--- hw/bae_event_select.sv
// bae_event_select: decodes event code and unit mask into a counter increment
// assumes: retirement inputs are per-cycle counts, stall inputs per-cycle levels
`timescale 1ns/10ps
`default_nettype none
`include "bae_defines.svh"

module bae_event_select #(
    parameter int INC_W = `BAE_INC_W,
    parameter int ROB_W = 6
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [`BAE_CODE_W-1:0] i_event_code,
    input wire logic [`BAE_MASK_W-1:0] i_unit_mask,
    input wire logic [INC_W-1:0] i_retired_near_ret_count,
    input wire logic [INC_W-1:0] i_retired_near_call_count,
    input wire logic [INC_W-1:0] i_retired_indirect_call_count,
    input wire logic [INC_W-1:0] i_retired_relative_call_count,
    input wire logic [INC_W-1:0] i_retired_taken_cond_jump_count,
    input wire logic [INC_W-1:0] i_mispredict_any_count,
    input wire logic [INC_W-1:0] i_mispredict_cond_jump_count,
    input wire logic [INC_W-1:0] i_mispredict_far_count,
    input wire logic [INC_W-1:0] i_mispredict_indirect_jmp_call_count,
    input wire logic [INC_W-1:0] i_mispredict_near_ret_count,
    input wire logic [INC_W-1:0] i_mispredict_near_call_count,
    input wire logic [INC_W-1:0] i_mispredict_indirect_call_count,
    input wire logic [INC_W-1:0] i_mispredict_relative_call_count,
    input wire logic [INC_W-1:0] i_mispredict_taken_cond_jump_count,
    input wire logic i_no_alloc,
    input wire logic [ROB_W-1:0] i_rob_free,
    input wire logic i_alias_table_stall,
    input wire logic i_fe_empty,
    input wire logic i_be_stall,
    output logic [INC_W-1:0] O_INCREMENT,
    output logic O_VALID_SEL,
    output bae_pkg::bae_sel_t O_SEL_CLASS
);
    import bae_pkg::*;

    // elaboration check on increment width
    if (INC_W < 1 || INC_W > 16) begin : g_bad_inc_w
        $error("INC_W out of range");
    end

    // ****************************************
    // allocation stall conditions
    // ****************************************
    logic stall_rob_full;
    logic stall_rat;
    logic stall_fe_any;
    logic stall_fe_not_deliv;

    bae_alloc_stall #(.ROB_W(ROB_W)) u_stall (
        .i_no_alloc(i_no_alloc),
        .i_rob_free(i_rob_free),
        .i_alias_stall(i_alias_table_stall),
        .i_fe_empty(i_fe_empty),
        .i_be_stall(i_be_stall),
        .o_rob_full(stall_rob_full),
        .o_rat_stall(stall_rat),
        .o_fe_any(stall_fe_any),
        .o_fe_not_deliv(stall_fe_not_deliv)
    );

    // ****************************************
    // selection decode
    // ****************************************
    function automatic logic sel_is(input logic [7:0] code, input logic [7:0] mask,
                                    input logic [7:0] want_code, input logic [7:0] want_mask);
        sel_is = (code == want_code) && (mask == want_mask);
    endfunction

    wire is_br = i_event_code == `BAE_EV_BR_RET;
    wire is_misp = i_event_code == `BAE_EV_BR_MISP;
    wire is_alloc = i_event_code == `BAE_EV_NO_ALLOC;
    wire [7:0] um = i_unit_mask;
    wire [7:0] ec = i_event_code;

    logic [INC_W-1:0] br_inc;
    logic [INC_W-1:0] misp_inc;
    logic alloc_hit;
    logic br_ok;
    logic misp_ok;
    logic alloc_ok;

    always_comb begin
        br_inc = '0;
        br_ok = 1'b1;
        if (um == `BAE_UM_RET) begin
            br_inc = i_retired_near_ret_count;
        end else if (um == `BAE_UM_CALL) begin
            br_inc = i_retired_near_call_count;
        end else if (um == `BAE_UM_IND_CALL) begin
            br_inc = i_retired_indirect_call_count;
        end else if (um == `BAE_UM_REL_CALL) begin
            br_inc = i_retired_relative_call_count;
        end else if (um == `BAE_UM_TAKEN_JCC) begin
            br_inc = i_retired_taken_cond_jump_count;
        end else begin
            br_ok = 1'b0;
        end
    end

    always_comb begin
        misp_inc = '0;
        misp_ok = 1'b1;
        if (um == `BAE_UM_ANY) begin
            misp_inc = i_mispredict_any_count;
        end else if (um == `BAE_UM_JCC) begin
            misp_inc = i_mispredict_cond_jump_count;
        end else if (um == `BAE_UM_FAR) begin
            misp_inc = i_mispredict_far_count;
        end else if (um == `BAE_UM_IND_JC) begin
            misp_inc = i_mispredict_indirect_jmp_call_count;
        end else if (um == `BAE_UM_RET) begin
            misp_inc = i_mispredict_near_ret_count;
        end else if (um == `BAE_UM_CALL) begin
            misp_inc = i_mispredict_near_call_count;
        end else if (um == `BAE_UM_IND_CALL) begin
            misp_inc = i_mispredict_indirect_call_count;
        end else if (um == `BAE_UM_REL_CALL) begin
            misp_inc = i_mispredict_relative_call_count;
        end else if (um == `BAE_UM_TAKEN_JCC) begin
            misp_inc = i_mispredict_taken_cond_jump_count;
        end else begin
            misp_ok = 1'b0;
        end
    end

    always_comb begin
        alloc_hit = 1'b0;
        alloc_ok = 1'b1;
        if (um == `BAE_UM_ROB_FULL) begin
            alloc_hit = stall_rob_full;
        end else if (um == `BAE_UM_RAT_STALL) begin
            alloc_hit = stall_rat;
        end else if (um == `BAE_UM_ALL) begin
            alloc_hit = stall_fe_any;
        end else if (um == `BAE_UM_NOT_DELIV) begin
            alloc_hit = stall_fe_not_deliv;
        end else begin
            alloc_ok = 1'b0;
        end
    end

    bae_sel_t next_sel;
    logic [INC_W-1:0] next_inc;
    assign next_sel = (is_br && br_ok) ? BAE_SEL_BR :
                      (is_misp && misp_ok) ? BAE_SEL_MISP :
                      (is_alloc && alloc_ok) ? BAE_SEL_ALLOC : BAE_SEL_NONE;

    always_comb begin
        case (next_sel)
            BAE_SEL_BR: begin
                next_inc = br_inc;
            end
            BAE_SEL_MISP: begin
                next_inc = misp_inc;
            end
            BAE_SEL_ALLOC: begin
                next_inc = INC_W'(alloc_hit);
            end
            default: begin
                next_inc = '0;
            end
        endcase
    end

    // ****************************************
    // output registers
    // ****************************************
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_INCREMENT <= '0;
            O_VALID_SEL <= 1'b0;
            O_SEL_CLASS <= BAE_SEL_NONE;
        end else begin
            O_INCREMENT <= next_inc;
            O_VALID_SEL <= next_sel != BAE_SEL_NONE;
            O_SEL_CLASS <= next_sel;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // return count
    near_ret_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_BR_RET, `BAE_UM_RET) |=> O_INCREMENT == $past(i_retired_near_ret_count))
        else $error("near return increment wrong");
    taken_jcc_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_BR_RET, `BAE_UM_TAKEN_JCC)
        |=> O_INCREMENT == $past(i_retired_taken_cond_jump_count))
        else $error("taken jcc increment wrong");
    misp_any_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_BR_MISP, `BAE_UM_ANY) |=> O_INCREMENT == $past(i_mispredict_any_count)
        && O_SEL_CLASS == BAE_SEL_MISP)
        else $error("any mispredict increment wrong");
    misp_ind_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_BR_MISP, `BAE_UM_IND_JC)
        |=> O_INCREMENT == $past(i_mispredict_indirect_jmp_call_count))
        else $error("indirect mispredict increment wrong");
    misp_taken_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_BR_MISP, `BAE_UM_TAKEN_JCC)
        |=> O_INCREMENT == $past(i_mispredict_taken_cond_jump_count))
        else $error("taken jcc mispredict wrong");
    rob_full_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_NO_ALLOC, `BAE_UM_ROB_FULL)
        |=> O_INCREMENT[0] == ($past(i_no_alloc) && $past(i_rob_free) < 2))
        else $error("reorder full cycle wrong");
    rat_stall_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_NO_ALLOC, `BAE_UM_RAT_STALL)
        |=> O_INCREMENT[0] == ($past(i_no_alloc) && $past(i_alias_table_stall)))
        else $error("alias stall cycle wrong");
    not_deliv_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        sel_is(ec, um, `BAE_EV_NO_ALLOC, `BAE_UM_NOT_DELIV)
        |=> O_INCREMENT[0] == ($past(i_fe_empty) && !$past(i_be_stall)))
        else $error("not delivered cycle wrong");
    undef_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !(is_br || is_misp || is_alloc) [*2] |=> O_INCREMENT == '0 && !O_VALID_SEL)
        else $error("undefined selection incremented");
endmodule // bae_event_select
`default_nettype wire

//--- testbench/bae_pipe_model.sv
// bae_pipe_model: pipeline stand-in driving per-cycle retirement counts
// assumes: bench updates its controls just after the clock edge
`timescale 1ns/10ps
`default_nettype none

module bae_pipe_model #(
    parameter int INC_W = 4
) (
    input wire logic [3:0] i_sel,
    input wire logic i_on,
    input wire logic [INC_W-1:0] i_cnt,
    input wire logic [INC_W-1:0] i_bg,
    output logic [13:0][INC_W-1:0] o_cnt
);
    // ****************************************
    // with i_on set, selected event gets i_cnt, others i_bg
    // ****************************************
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            o_cnt[i] = (i_on && i_sel == 4'(i)) ? i_cnt : i_bg;
        end
    end
endmodule // bae_pipe_model

`default_nettype wire

//--- testbench/test_branch_alloc_event_select.sv
// test_branch_alloc_event_select: self-checking bench for the event decoder
// assumes: 125 MHz clock, one-cycle registered outputs
`timescale 1ns/10ps
`default_nettype none
`include "bae_defines.svh"

module test_branch_alloc_event_select;
    import bae_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic [7:0] code = 8'h00;
    logic [7:0] mask = 8'h00;
    logic [3:0] sel = 4'h0;
    logic on = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [3:0] bg = 4'h0;
    logic na = 1'b0;
    logic [5:0] rob = 6'h3f;
    logic rat = 1'b0;
    logic fe = 1'b0;
    logic be = 1'b0;
    wire logic [13:0][3:0] ev;
    logic [3:0] inc;
    logic vsel;
    bae_sel_t cls;
    int error_cnt = 0;
    int tests_run = 0;
    localparam logic [7:0] BR_MASK [14] = '{8'hf7, 8'hf9, 8'hfb, 8'hfd, 8'hfe, 8'h00,
        8'h7e, 8'hbf, 8'heb, 8'hf7, 8'hf9, 8'hfb, 8'hfd, 8'hfe};

    always #4 I_CLK = ~I_CLK;

    bae_pipe_model #(.INC_W(4)) pipe (.i_sel(sel), .i_on(on), .i_cnt(cnt), .i_bg(bg),
        .o_cnt(ev));

    bae_event_select #(.INC_W(4), .ROB_W(6)) uut (
        .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_event_code(code), .i_unit_mask(mask),
        .i_retired_near_ret_count(ev[0]), .i_retired_near_call_count(ev[1]),
        .i_retired_indirect_call_count(ev[2]), .i_retired_relative_call_count(ev[3]),
        .i_retired_taken_cond_jump_count(ev[4]), .i_mispredict_any_count(ev[5]),
        .i_mispredict_cond_jump_count(ev[6]), .i_mispredict_far_count(ev[7]),
        .i_mispredict_indirect_jmp_call_count(ev[8]), .i_mispredict_near_ret_count(ev[9]),
        .i_mispredict_near_call_count(ev[10]), .i_mispredict_indirect_call_count(ev[11]),
        .i_mispredict_relative_call_count(ev[12]),
        .i_mispredict_taken_cond_jump_count(ev[13]), .i_no_alloc(na), .i_rob_free(rob),
        .i_alias_table_stall(rat), .i_fe_empty(fe), .i_be_stall(be),
        .O_INCREMENT(inc), .O_VALID_SEL(vsel), .O_SEL_CLASS(cls));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic outs(input logic [3:0] e_inc, input logic e_v, input bae_sel_t e_cls);
        chk("increment", 16'(e_inc), 16'(inc));
        chk("valid", 16'(e_v), 16'(vsel));
        chk("class", 16'(e_cls), 16'(cls));
    endtask

    // apply selection, let one edge pass, judge outputs
    task automatic step(input logic [7:0] c, input logic [7:0] m, input logic [3:0] e_inc,
                        input logic e_v, input bae_sel_t e_cls);
        code = c;
        mask = m;
        @(posedge I_CLK);
        #1;
        outs(e_inc, e_v, e_cls);
    endtask

    task automatic alloc(input logic [7:0] m, input logic n, input logic [5:0] r,
                         input logic a, input logic f, input logic b, input logic e);
        na = n;
        rob = r;
        rat = a;
        fe = f;
        be = b;
        step(8'hca, m, 4'(e), 1'b1, BAE_SEL_ALLOC);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        repeat (10) @(posedge I_CLK);
        #1;
        outs(4'h0, 1'b0, BAE_SEL_NONE);
        on = 1'b1;
        cnt = 4'h9;
        step(8'hc4, 8'hf7, 4'h9, 1'b1, BAE_SEL_BR);
        I_RESET_N = 1'b0;
        #1;
        outs(4'h0, 1'b0, BAE_SEL_NONE);
        @(posedge I_CLK);
        #1;
        outs(4'h0, 1'b0, BAE_SEL_NONE);
        I_RESET_N = 1'b1;
        step(8'hc4, 8'hf7, 4'h9, 1'b1, BAE_SEL_BR);
        $display("test_reset done");
    endtask

    task automatic test_branch();
        logic [3:0] v;
        on = 1'b1;
        bg = 4'h1;
        for (int j = 0; j < 3; j++) begin
            for (int i = 0; i < 14; i++) begin
                v = (j == 0) ? 4'h0 : (j == 1) ? 4'(i + 2) : 4'hf;
                sel = 4'(i);
                cnt = v;
                step((i < 5) ? 8'hc4 : 8'hc5, BR_MASK[i], v, 1'b1,
                     (i < 5) ? BAE_SEL_BR : BAE_SEL_MISP);
            end
        end
        $display("test_branch done");
    endtask

    task automatic test_alloc();
        on = 1'b0;
        alloc(8'h01, 1'b1, 6'h01, 1'b0, 1'b0, 1'b1, 1'b1);
        alloc(8'h01, 1'b1, 6'h02, 1'b1, 1'b1, 1'b0, 1'b0);
        alloc(8'h01, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0, 1'b1);
        alloc(8'h01, 1'b0, 6'h00, 1'b1, 1'b1, 1'b1, 1'b0);
        alloc(8'h20, 1'b1, 6'h3f, 1'b1, 1'b0, 1'b0, 1'b1);
        alloc(8'h20, 1'b0, 6'h00, 1'b1, 1'b1, 1'b0, 1'b0);
        alloc(8'h20, 1'b1, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0);
        alloc(8'h3f, 1'b0, 6'h3f, 1'b0, 1'b1, 1'b1, 1'b1);
        alloc(8'h3f, 1'b1, 6'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        alloc(8'h50, 1'b0, 6'h3f, 1'b0, 1'b1, 1'b0, 1'b1);
        alloc(8'h50, 1'b0, 6'h3f, 1'b0, 1'b1, 1'b1, 1'b0);
        alloc(8'h50, 1'b1, 6'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        $display("test_alloc done");
    endtask

    task automatic test_undefined();
        logic [15:0] bad [8] = '{16'hc4f8, 16'hc4ff, 16'hc501, 16'hc3f7, 16'hca00,
                                 16'hca3e, 16'h0000, 16'hc600};
        on = 1'b1;
        sel = 4'h0;
        cnt = 4'h5;
        bg = 4'h3;
        na = 1'b1;
        rob = 6'h00;
        rat = 1'b1;
        fe = 1'b1;
        be = 1'b0;
        for (int i = 0; i < 8; i++) begin
            step(bad[i][15:8], bad[i][7:0], 4'h0, 1'b0, BAE_SEL_NONE);
        end
        $display("test_undefined done");
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (20) @(posedge I_CLK);
        #1;
        I_RESET_N = 1'b1;
        test_reset();
        test_branch();
        test_alloc();
        test_undefined();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge I_CLK);
        error_cnt++;
        final_report();
    end
endmodule // test_branch_alloc_event_select

`default_nettype wire
